// [shared/els_pkg.sv]
// constants, field layouts and carrier types of the link and slot registers
package els_pkg;

    // ********************************************************************
    // register map (byte addresses on the register bus)
    // ********************************************************************
    localparam logic [7:0] ELS_OFF_LINK = 8'hC0; // control low, status high
    localparam logic [7:0] ELS_OFF_SLOT = 8'hC4; // slot capability
    localparam int ELS_ADDR_W = 8;
    localparam int ELS_DATA_W = 32;

    // ********************************************************************
    // link control fields, low half of the link word
    // ********************************************************************
    localparam int ELS_LC_ASPM_LSB = 0;
    localparam int ELS_LC_RCB = 3;
    localparam int ELS_LC_LDIS = 4;
    localparam int ELS_LC_RETRAIN = 5;
    localparam int ELS_LC_CCLK = 6;
    localparam int ELS_LC_ESYNC = 7;
    localparam logic [1:0] ELS_ASPM_RST = 2'h0;
    localparam logic [1:0] ELS_ASPM_OFF = 2'h0;
    localparam logic [1:0] ELS_ASPM_L0S = 2'h1;
    localparam logic [1:0] ELS_ASPM_L1 = 2'h2;
    localparam logic [1:0] ELS_ASPM_BOTH = 2'h3;

    // ********************************************************************
    // link status fields, high half of the link word
    // ********************************************************************
    localparam int ELS_LS_SPEED_LSB = 16;
    localparam int ELS_LS_WIDTH_LSB = 20;
    localparam int ELS_LS_TERR = 26;
    localparam int ELS_LS_TRAINING = 27;
    localparam int ELS_LS_SCLK = 28;
    localparam logic [3:0] ELS_SPEED_2G5 = 4'h1;
    localparam logic ELS_SCLK_RST = 1'b1;
    localparam logic [5:0] ELS_WIDTH_X1 = 6'h01;
    localparam logic [5:0] ELS_WIDTH_X2 = 6'h02;
    localparam logic [5:0] ELS_WIDTH_X4 = 6'h04;
    localparam logic [5:0] ELS_WIDTH_X8 = 6'h08;
    localparam logic [5:0] ELS_WIDTH_X12 = 6'h0C;
    localparam logic [5:0] ELS_WIDTH_X16 = 6'h10;
    localparam logic [5:0] ELS_WIDTH_X32 = 6'h20;

    // ********************************************************************
    // slot capability fields
    // ********************************************************************
    localparam int ELS_SC_ATTN_BTN = 0;
    localparam int ELS_SC_MRL = 2;
    localparam int ELS_SC_ATTN_IND = 3;
    localparam int ELS_SC_PWR_IND = 4;
    localparam int ELS_SC_HP_CAP = 6;

    // ********************************************************************
    // carrier types
    // ********************************************************************
    typedef struct packed {
        logic ext_sync;
        logic common_clk;
        logic retrain;
        logic link_dis;
        logic [1:0] aspm;
    } els_link_ctrl_t;

    localparam els_link_ctrl_t ELS_CTRL_RST = '{
        ext_sync: 1'b0, common_clk: 1'b0, retrain: 1'b0,
        link_dis: 1'b0, aspm: ELS_ASPM_RST
    };

    typedef struct packed {
        logic training;
        logic train_err;
        logic [5:0] width;
    } els_link_state_t;

endpackage

// [src/els_width_hold.sv]
// holder of the negotiated link width, refusing undefined codes
`timescale 1ns/1ps
module els_width_hold
    import els_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // raw width from the training logic
    input wire logic [5:0] width_i,
    // width as software sees it
    output logic [5:0] width_o
);

    logic [5:0] width;
    logic [5:0] next_width;

    // only listed codes pass; anything else keeps the last good width
    always_comb begin
        next_width = width;
        case (width_i)
            ELS_WIDTH_X1, ELS_WIDTH_X2, ELS_WIDTH_X4, ELS_WIDTH_X8,
            ELS_WIDTH_X12, ELS_WIDTH_X16, ELS_WIDTH_X32: begin
                next_width = width_i;
            end
            default: begin
                next_width = width; // zero never reaches software
            end
        endcase
    end

    // width register, x1 out of reset
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            width <= ELS_WIDTH_X1;
        end else begin
            width <= next_width;
        end
    end

    assign width_o = width;

endmodule

// [src/els_regs.sv]
// link control, link status and slot capability registers on avalon-mm
//
// Functional notes
// - The two-bit power-management field enables L0s, L1, both or none and resets to 00.
// - The read completion boundary bit always reads zero and ignores writes.
// - Link disable and retrain are writable only in reverse mode, read-only in forward mode, and reset to zero.
// - The link speed field is read-only and holds the 2.5Gb/s code, one, from reset.
// - The five hot-plug presence bits of slot capability read one only with the hot-plug strap in reverse mode.
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module els_regs
    import els_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // avalon-mm slave
    input wire logic [ELS_ADDR_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [ELS_DATA_W-1:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [ELS_DATA_W-1:0] readdata_o,
    output logic waitrequest_o,
    // straps, caught while reset is held
    input wire logic strap_reverse_i,
    input wire logic strap_hotplug_i,
    // link state from the training logic
    input wire logic [5:0] link_width_i,
    input wire logic link_train_err_i,
    input wire logic link_training_i,
    // control towards the link
    output els_link_ctrl_t link_ctrl_o,
    output logic reverse_mode_o,
    output logic hotplug_en_o
);

    // ********************************************************************
    // helpers
    // ********************************************************************

    // word match; the two low address bits do not take part
    function automatic logic hits(
        input logic [ELS_ADDR_W-1:0] addr,
        input logic [ELS_ADDR_W-1:0] off
    );
        hits = (addr[ELS_ADDR_W-1:2] == off[ELS_ADDR_W-1:2]);
    endfunction

    // ********************************************************************
    // strap capture
    // ********************************************************************

    logic reverse_mode;
    logic hotplug_en;
    logic next_reverse_mode;
    logic next_hotplug_en;

    // straps sampled on every clock edge while reset is held, frozen after release
    always_comb begin
        next_reverse_mode = reverse_mode;
        next_hotplug_en = hotplug_en;
        if (rst_i) begin
            next_reverse_mode = strap_reverse_i;
            next_hotplug_en = strap_reverse_i & strap_hotplug_i;
        end
    end

    // synchronous reset, so loading a strap here is a plain clocked load
    always_ff @(posedge clock_i) begin
        reverse_mode <= next_reverse_mode;
        hotplug_en <= next_hotplug_en;
    end

    // ********************************************************************
    // bus handshake
    // ********************************************************************

    logic waitrequest;
    logic next_waitrequest;
    logic req;
    logic take;
    logic wr_take;

    assign req = read_i | write_i;
    // a request is answered on the edge where waitrequest is low
    assign take = req & ~waitrequest;
    assign wr_take = write_i & ~waitrequest;

    // one wait cycle per access: high on arrival, low the next cycle
    always_comb begin
        next_waitrequest = 1'b1;
        if (req && waitrequest) begin
            next_waitrequest = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= next_waitrequest;
        end
    end

    // ********************************************************************
    // link control
    // ********************************************************************

    els_link_ctrl_t ctrl;
    els_link_ctrl_t next_ctrl;
    logic ctrl_wr;
    logic [7:0] wbyte;

    assign ctrl_wr = wr_take & hits(address_i, ELS_OFF_LINK)
                     & byteenable_i[0];
    assign wbyte = writedata_i[7:0];

    // byte 0 of the link word; byte 1 is reserved and ignored
    always_comb begin
        next_ctrl = ctrl;
        if (ctrl_wr) begin
            next_ctrl.aspm = wbyte[ELS_LC_ASPM_LSB +: 2];
            next_ctrl.common_clk = wbyte[ELS_LC_CCLK];
            next_ctrl.ext_sync = wbyte[ELS_LC_ESYNC];
            // forward bridge keeps these at their reset value
            if (reverse_mode) begin
                next_ctrl.link_dis = wbyte[ELS_LC_LDIS];
                next_ctrl.retrain = wbyte[ELS_LC_RETRAIN];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl <= ELS_CTRL_RST;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // ********************************************************************
    // link status
    // ********************************************************************

    els_link_state_t lstate;
    els_link_state_t next_lstate;
    logic [5:0] width;

    // the holder screens out codes the training logic should never give
    els_width_hold u_width (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .width_i(link_width_i),
        .width_o(width)
    );

    // flags registered so a read sees one settled snapshot
    always_comb begin
        next_lstate.width = width;
        next_lstate.train_err = link_train_err_i;
        next_lstate.training = link_training_i;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            lstate.width <= ELS_WIDTH_X1;
            lstate.train_err <= 1'b0;
            lstate.training <= 1'b0;
        end else begin
            lstate <= next_lstate;
        end
    end

    // ********************************************************************
    // read path
    // ********************************************************************

    logic [ELS_DATA_W-1:0] rdata;
    logic [ELS_DATA_W-1:0] next_rdata;
    logic [ELS_DATA_W-1:0] link_word;
    logic [ELS_DATA_W-1:0] slot_word;

    // link word: control below, status above, reserved bits zero
    always_comb begin
        link_word = '0;
        link_word[ELS_LC_ASPM_LSB +: 2] = ctrl.aspm;
        link_word[ELS_LC_RCB] = 1'b0; // no boundary choice
        link_word[ELS_LC_LDIS] = ctrl.link_dis;
        link_word[ELS_LC_RETRAIN] = ctrl.retrain;
        link_word[ELS_LC_CCLK] = ctrl.common_clk;
        link_word[ELS_LC_ESYNC] = ctrl.ext_sync;
        link_word[ELS_LS_SPEED_LSB +: 4] = ELS_SPEED_2G5;
        link_word[ELS_LS_WIDTH_LSB +: 6] = lstate.width;
        link_word[ELS_LS_TERR] = lstate.train_err;
        link_word[ELS_LS_TRAINING] = lstate.training;
        link_word[ELS_LS_SCLK] = ELS_SCLK_RST;
    end

    // slot capability: only the hot-plug presence bits can be one
    always_comb begin
        slot_word = '0;
        slot_word[ELS_SC_ATTN_BTN] = hotplug_en;
        slot_word[ELS_SC_MRL] = hotplug_en;
        slot_word[ELS_SC_ATTN_IND] = hotplug_en;
        slot_word[ELS_SC_PWR_IND] = hotplug_en;
        slot_word[ELS_SC_HP_CAP] = hotplug_en;
    end

    // data captured on the arrival edge, stands through the answer cycle
    always_comb begin
        next_rdata = rdata;
        if (read_i && waitrequest) begin
            if (hits(address_i, ELS_OFF_LINK)) begin
                next_rdata = link_word;
            end else if (hits(address_i, ELS_OFF_SLOT)) begin
                next_rdata = slot_word;
            end else begin
                next_rdata = '0; // unmapped reads as zero
            end
        end else if (take) begin
            next_rdata = '0; // cleared once the answer is taken
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ********************************************************************
    // outputs, all straight from flip-flops
    // ********************************************************************

    assign readdata_o = rdata;
    assign waitrequest_o = waitrequest;
    assign link_ctrl_o = ctrl;
    assign reverse_mode_o = reverse_mode;
    assign hotplug_en_o = hotplug_en;

endmodule

// [verification/els_regs_chk.sv]
// assertions on the link and slot register bank ports
`timescale 1ns/1ps
module els_regs_chk
    import els_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // register bus
    input wire logic [ELS_ADDR_W-1:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [ELS_DATA_W-1:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    input wire logic [ELS_DATA_W-1:0] readdata_o,
    input wire logic waitrequest_o,
    // straps and link control
    input wire logic strap_reverse_i,
    input wire logic strap_hotplug_i,
    input wire els_link_ctrl_t link_ctrl_o
);
    // ****
    // strap copies, caught while reset is held
    // ****
    logic rev_q;
    logic hp_q;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rev_q <= strap_reverse_i;
            hp_q <= strap_reverse_i & strap_hotplug_i;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // word selects, bits 1:0 of the address ignored
    wire link_a = address_i[7:2] == ELS_OFF_LINK[7:2];
    wire slot_a = address_i[7:2] == ELS_OFF_SLOT[7:2];
    sequence s_rd_link;
        read_i && !waitrequest_o && link_a;
    endsequence
    sequence s_rd_done;
        read_i && !waitrequest_o;
    endsequence
    sequence s_wr_ctrl;
        write_i && !waitrequest_o && link_a && byteenable_i[0];
    endsequence
    property p_aspm;
        s_wr_ctrl |=> link_ctrl_o.aspm == $past(writedata_i[1:0]);
    endproperty
    a_aspm: assert property (p_aspm)
        else $error("power field not taken");
    property p_rcb;
        s_rd_link |-> readdata_o[3] == 1'b0;
    endproperty
    a_rcb: assert property (p_rcb)
        else $error("boundary bit not zero");
    property p_fwd;
        !rev_q |-> !link_ctrl_o.link_dis && !link_ctrl_o.retrain;
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("forward bits written");
    property p_rev;
        s_wr_ctrl ##0 rev_q |=> link_ctrl_o.retrain == $past(writedata_i[5]);
    endproperty
    a_rev: assert property (p_rev)
        else $error("retrain not taken");
    property p_speed;
        s_rd_link |-> readdata_o[19:16] == ELS_SPEED_2G5;
    endproperty
    a_speed: assert property (p_speed)
        else $error("speed code wrong");
    property p_slot;
        read_i && !waitrequest_o && slot_a |-> readdata_o ==
            {25'h0, hp_q, 1'b0, {3{hp_q}}, 1'b0, hp_q};
    endproperty
    a_slot: assert property (p_slot)
        else $error("slot bits wrong");
    property p_width;
        s_rd_link |-> readdata_o[25:20] != 6'h00;
    endproperty
    a_width: assert property (p_width)
        else $error("width all zero");
    // bus contract: one answer cycle, then read data fall back to zero
    property p_one_wait;
        !waitrequest_o |=> waitrequest_o;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("waitrequest low twice");
    property p_rd_clear;
        s_rd_done |=> readdata_o == '0;
    endproperty
    a_rd_clear: assert property (p_rd_clear)
        else $error("read data not cleared");
endmodule
bind els_regs els_regs_chk u_chk (.clock_i, .rst_i, .address_i, .read_i,
    .write_i, .writedata_i, .byteenable_i, .readdata_o, .waitrequest_o,
    .strap_reverse_i, .strap_hotplug_i, .link_ctrl_o);

// [verification/els_link_model.sv]
// stand-in for the link training logic feeding width and flags
`timescale 1ns/1ps
module els_link_model (
    // clock and requested state
    input wire logic clock_i,
    input wire logic [7:0] set_i,
    // raw state towards the bank
    output logic [5:0] width_o,
    output logic err_o,
    output logic trn_o
);
    // moves only at edges, as a trainer would; one driver per output
    always @(posedge clock_i) begin
        {trn_o, err_o, width_o} <= set_i;
    end
endmodule

// [verification/express_link_slot_regs_test.sv]
// self-checking bench for the link and slot register bank
`timescale 1ns/1ps
module express_link_slot_regs_test
    import els_pkg::*;
;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'h0;
    logic s_rev = 1'b0;
    logic s_hp = 1'b1;
    logic [7:0] set = 8'h01;
    logic [31:0] rdata;
    logic [31:0] got;
    logic wreq;
    logic [5:0] width;
    logic err;
    logic trn;
    logic rev_o;
    logic hp_o;
    els_link_ctrl_t ctrl;
    logic [5:0] wexp;
    logic [5:0] wtab [9] = '{6'h02, 6'h00, 6'h03, 6'h20, 6'h0C,
                             6'h10, 6'h08, 6'h04, 6'h01};
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    always #20 clock_i = ~clock_i;
    els_link_model u_link (.clock_i(clock_i), .set_i(set),
        .width_o(width), .err_o(err), .trn_o(trn));
    els_regs DUT (.clock_i(clock_i), .rst_i(rst_i), .address_i(addr),
        .read_i(rd), .write_i(wr), .writedata_i(wdata),
        .byteenable_i(be), .readdata_o(rdata), .waitrequest_o(wreq),
        .strap_reverse_i(s_rev), .strap_hotplug_i(s_hp),
        .link_width_i(width), .link_train_err_i(err),
        .link_training_i(trn), .link_ctrl_o(ctrl),
        .reverse_mode_o(rev_o), .hotplug_en_o(hp_o));
    // ****
    // bus and compare tasks
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // request held until the edge that sees waitrequest low
    task automatic bus(input logic r, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] b);
        @(posedge clock_i);
        addr <= a;
        rd <= r;
        wr <= !r;
        wdata <= d;
        be <= b;
        do @(posedge clock_i); while (wreq !== 1'b0);
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b1, a, 32'h0, 4'h0);
        chk(got, exp);
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard, far above the 150 or so cycles needed
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        // forward mode with hot-plug strap: slot bits stay low
        rdc(ELS_OFF_LINK, 32'h1011_0000);
        rdc(ELS_OFF_SLOT, 32'h0);
        rdc(8'h80, 32'h0);
        chk({30'h0, rev_o, hp_o}, 32'h0);
        $display("reset test done");
        // every power code, read-only bits written high
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, ELS_OFF_LINK, 32'hFFFF_FFF8 | i, 4'hF);
            rdc(ELS_OFF_LINK, 32'h1011_00C0 | i);
            chk({30'h0, ctrl.aspm}, i);
        end
        $display("control test done");
        // undefined width codes must leave the last good one
        wexp = 6'h01;
        foreach (wtab[k]) begin
            set <= {2'b11, wtab[k]};
            if (wtab[k] inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h0C,
                                6'h10, 6'h20})
                wexp = wtab[k];
            repeat (4) @(posedge clock_i);
            rdc(ELS_OFF_LINK, {4'h1, 2'b11, wexp, 20'h100C3});
        end
        $display("width test done");
        // reverse mode with hot-plug
        rst_i <= 1'b1;
        s_rev <= 1'b1;
        set <= 8'h01;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        rdc(ELS_OFF_SLOT, 32'h5D);
        chk({30'h0, rev_o, hp_o}, 32'h3);
        bus(1'b0, ELS_OFF_SLOT, 32'hFFFF_FFFF, 4'hF);
        rdc(ELS_OFF_SLOT, 32'h5D);
        bus(1'b0, ELS_OFF_LINK, 32'h30, 4'h1);
        rdc(ELS_OFF_LINK, 32'h1011_0030);
        chk({26'h0, ctrl}, 32'h0C);
        $display("reverse test done");
        // reverse mode without hot-plug; link bits back at reset value
        rst_i <= 1'b1;
        s_hp <= 1'b0;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        rdc(ELS_OFF_SLOT, 32'h0);
        chk({30'h0, rev_o, hp_o}, 32'h2);
        rdc(ELS_OFF_LINK, 32'h1011_0000);
        $display("no hot-plug test done");
        print_verdict();
    end
endmodule
